// *** rtl/cxs_sequencer.sv ***
// Purpose: exception sequencer: reset, trace, interrupt, trap
// Assumes: cpu pipeline gives instruction completion strobes
// Notes: one clock; apb slave for control and state
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - reset outranks every other exception, pending or in progress.
// - while reset pin low, halt and initialise cpu and module state.
// - after any reset, interrupt control mode 0 is selected.
// - reset sequence starts when reset pin returns high.
// - nmi pin high at reset means power-on, low means manual.
// - watchdog overflow also resets, with either reset type.
// - manual reset keeps bus controller and port registers.
// - manual reset returns peripheral pins to general ports.
// - reset clears trace flag and sets global mask in both registers.
// - after init, reset vector is fetched and execution starts there.
// - right after reset every interrupt, nmi included, is blocked.
// - on release module stop control loads 3fff.
// - trace works only in mode 2 with trace flag set.
// - trace raises exception after each instruction, ignores masking.
// - trace entry sets global mask, clears trace flag, keeps others.
// - interrupts allowed in trace handler; no trace after return.
// - trap accepted any time in execution, vector from 2-bit number.
// - trap sets global mask; mode 2 also clears trace flag.
// - nine external and 43 internal interrupt sources, own vectors.
// - vector numbering 0,1,5,7,8-11,16-23,24-87; others reserved.
// - vector addresses on low 16 bits, 2 or 4 byte entries.
// - word and longword accesses force address bit 0 low.
// - simultaneous exceptions: reset, trace, interrupt, trap.
// - trap/interrupt push, update masks, clear trace, jump; reset jumps only.
// - no interrupt check after control-op instructions or reset handling.
module cxs_sequencer
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins
    input wire logic reset_pin_low,
    input wire logic nmi_pin,
    input wire logic wdt_overflow,
    input wire logic wdt_type_manual,
    // interrupt requests
    input wire logic [7:0] external_request_lines,
    input wire logic [42:0] internal_requests,
    input wire logic [2:0] internal_level,
    // cpu pipeline
    input wire logic insn_done,
    input wire logic insn_ctrl_op,
    input wire logic insn_rte,
    input wire logic [1:0] rte_flags,
    input wire logic trap_opcode,
    input wire logic [1:0] trap_num,
    input wire logic stack_done,
    input wire logic sp_loaded,
    input wire logic [15:0] cpu_addr,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // outputs to cpu and modules
    output logic cpu_halt,
    output logic periph_init,
    output logic busport_init,
    output logic pins_to_ports,
    output logic push_req,
    output logic vec_fetch,
    output logic [15:0] vec_addr,
    output logic [15:0] mem_addr,
    output logic [15:0] module_stop_control,
    output logic [1:0] ctrl_mode,
    output logic manual_reset_flag
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, change counted when 2nd and 3rd agree
    logic [2:0] rs_sync_reg, nmi_sync_reg;
    logic rs_low_reg, nmi_hi_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rs_sync_reg <= 3'h7;
            // nmi taken as high: nrst is a power-on reset and must not see a false nmi edge
            nmi_sync_reg <= 3'h7;
            rs_low_reg <= 1'b1;
            nmi_hi_reg <= 1'b1;
        end
        else
        begin
            rs_sync_reg <= {rs_sync_reg[1:0], reset_pin_low};
            nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
            if (rs_sync_reg[2] == rs_sync_reg[1])
                rs_low_reg <= ~rs_sync_reg[1];
            if (nmi_sync_reg[2] == nmi_sync_reg[1])
                nmi_hi_reg <= nmi_sync_reg[1];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registered requests
    logic [7:0] ext_reg;
    logic [42:0] int_reg;
    logic nmi_prev_reg, nmi_pend_reg, wdt_reg, wdt_man_reg;
    logic trap_reg;
    logic [1:0] trap_num_reg;
    wire nmi_edge = nmi_hi_reg & ~nmi_prev_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_reg <= 8'h00;
            int_reg <= '0;
            wdt_reg <= 1'b0;
            wdt_man_reg <= 1'b0;
            nmi_prev_reg <= 1'b1;
        end
        else
        begin
            ext_reg <= external_request_lines;
            int_reg <= internal_requests;
            wdt_reg <= wdt_overflow;
            wdt_man_reg <= wdt_type_manual;
            nmi_prev_reg <= nmi_hi_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control state
    cxs_pkg::cxs_state_t state_reg, state_next;
    logic t_reg, i_reg, ui_reg, adv_reg, blocked_reg, no_check_reg;
    logic [2:0] lvl_reg;
    logic [6:0] vec_num_reg;
    logic kind_trap_reg, kind_trace_reg;
    logic [1:0] mode_sel;
    assign mode_sel = ctrl_mode;

    // apb decode
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire hit_ctrl = paddr == cxs_pkg::OFS_CTRL;
    wire hit_flags = paddr == cxs_pkg::OFS_FLAGS;
    wire hit_mstop = paddr == cxs_pkg::OFS_MSTOP;
    wire hit_status = paddr == cxs_pkg::OFS_STATUS;
    wire hit_vector = paddr == cxs_pkg::OFS_VECTOR;
    wire hit_any = hit_ctrl | hit_flags | hit_mstop | hit_status | hit_vector;
    wire [1:0] wr_mode = pwdata[cxs_pkg::CTRL_MODE_LO +: 2];
    wire wr_mode_ok = (wr_mode == cxs_pkg::MODE_0) | (wr_mode == cxs_pkg::MODE_2);

    // requests and arbitration
    wire trace_on = (mode_sel == cxs_pkg::MODE_2) & t_reg;
    wire trace_ev = trace_on & insn_done & ~insn_rte;
    wire ext_masked = (mode_sel == cxs_pkg::MODE_2) ? (lvl_reg == 3'h7) : i_reg;
    wire ext_any = |ext_reg & ~ext_masked;
    wire int_any = |int_reg & ((mode_sel == cxs_pkg::MODE_2) ? (internal_level > lvl_reg) : ~i_reg);
    wire check_ok = insn_done & ~insn_ctrl_op & ~no_check_reg & ~blocked_reg;
    wire irq_ev = check_ok & (nmi_pend_reg | ext_any | int_any);
    wire trap_ev = trap_reg;
    logic [2:0] ext_idx;
    logic [5:0] int_idx;
    always_comb
    begin
        ext_idx = 3'h0;
        int_idx = 6'h00;
        for (int k = cxs_pkg::NUM_EXT - 1; k >= 0; k--)
            if (ext_reg[k])
                ext_idx = 3'(k);
        for (int k = cxs_pkg::NUM_INT - 1; k >= 0; k--)
            if (int_reg[k])
                int_idx = 6'(k);
    end
    // priority select
    wire [6:0] irq_vec = nmi_pend_reg ? cxs_pkg::VEC_NMI :
        ext_any ? cxs_pkg::VEC_EXT_BASE + 7'(ext_idx) : cxs_pkg::VEC_INT_BASE + 7'(int_idx);
    wire [6:0] trap_vec = cxs_pkg::VEC_TRAP_BASE + 7'(trap_num_reg);
    wire [6:0] sel_vec = trace_ev ? cxs_pkg::VEC_TRACE : irq_ev ? irq_vec : trap_vec;
    wire take_exc = (state_reg == cxs_pkg::CXS_RUN) & (trace_ev | irq_ev | trap_ev);
    wire reset_now = rs_low_reg | wdt_reg;
    wire reset_type_manual = wdt_reg ? wdt_man_reg : ~nmi_hi_reg;
    // vector address on low 16 bits
    wire [15:0] vaddr = adv_reg ? {7'h00, vec_num_reg, 2'b00} : {8'h00, vec_num_reg, 1'b0};

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            cxs_pkg::CXS_RESET:
                if (!reset_now)
                    state_next = cxs_pkg::CXS_VEC;
            cxs_pkg::CXS_RUN:
                if (take_exc)
                    state_next = cxs_pkg::CXS_STACK;
            cxs_pkg::CXS_STACK:
                if (stack_done)
                    state_next = cxs_pkg::CXS_VEC;
            cxs_pkg::CXS_VEC:
                state_next = cxs_pkg::CXS_JUMP;
            cxs_pkg::CXS_JUMP:
                state_next = cxs_pkg::CXS_RUN;
            default:
                state_next = cxs_pkg::CXS_RESET;
        endcase
        if (reset_now)
            state_next = cxs_pkg::CXS_RESET;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= cxs_pkg::CXS_RESET;
        else
            state_reg <= state_next;
    end

    // flag and mode registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            t_reg <= 1'b0;
            i_reg <= 1'b1;
            ui_reg <= 1'b0;
            lvl_reg <= 3'h7;
            ctrl_mode <= cxs_pkg::MODE_0;
            adv_reg <= 1'b0;
            blocked_reg <= 1'b1;
            no_check_reg <= 1'b1;
            vec_num_reg <= cxs_pkg::VEC_POWER_ON;
            kind_trap_reg <= 1'b0;
            kind_trace_reg <= 1'b0;
            manual_reset_flag <= 1'b0;
            nmi_pend_reg <= 1'b0;
            trap_reg <= 1'b0;
            trap_num_reg <= 2'h0;
        end
        else if (reset_now)
        begin
            t_reg <= 1'b0;
            i_reg <= 1'b1;
            lvl_reg <= 3'h7;
            ctrl_mode <= cxs_pkg::MODE_0;
            blocked_reg <= 1'b1;
            no_check_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
            trap_reg <= 1'b0;
            manual_reset_flag <= reset_type_manual;
            vec_num_reg <= reset_type_manual ? cxs_pkg::VEC_MANUAL : cxs_pkg::VEC_POWER_ON;
        end
        else
        begin
            // nmi pending: edge sets, acceptance clears; set wins
            if (nmi_edge)
                nmi_pend_reg <= 1'b1;
            else if (take_exc & ~trace_ev & irq_ev & nmi_pend_reg)
                nmi_pend_reg <= 1'b0;
            if (trap_opcode & (state_reg == cxs_pkg::CXS_RUN))
            begin
                trap_reg <= 1'b1;
                trap_num_reg <= trap_num;
            end
            else if (take_exc & ~trace_ev & ~irq_ev)
                trap_reg <= 1'b0;
            if (sp_loaded)
                blocked_reg <= 1'b0;
            if (insn_done)
                no_check_reg <= 1'b0;
            if (take_exc)
            begin
                vec_num_reg <= sel_vec;
                kind_trace_reg <= trace_ev;
                kind_trap_reg <= ~trace_ev & ~irq_ev;
                i_reg <= 1'b1;
                if (mode_sel == cxs_pkg::MODE_2)
                    t_reg <= 1'b0;
            end
            else if (insn_rte)
            begin
                t_reg <= rte_flags[0];
                i_reg <= rte_flags[1];
            end
            else if (apb_wr & hit_flags)
            begin
                t_reg <= pwdata[cxs_pkg::FL_T];
                i_reg <= pwdata[cxs_pkg::FL_I];
                ui_reg <= pwdata[cxs_pkg::FL_UI];
                lvl_reg <= pwdata[cxs_pkg::FL_LVL_LO +: 3];
            end
            if (apb_wr & hit_ctrl)
            begin
                if (wr_mode_ok)
                    ctrl_mode <= wr_mode;
                adv_reg <= pwdata[cxs_pkg::CTRL_ADV];
            end
        end
    end

    // module stop, loaded on release, software writable afterwards
    logic reset_prev_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            module_stop_control <= cxs_pkg::MSTOP_RESET;
            reset_prev_reg <= 1'b1;
        end
        else
        begin
            reset_prev_reg <= reset_now;
            if (reset_prev_reg & ~reset_now)
                module_stop_control <= cxs_pkg::MSTOP_RESET;
            else if (apb_wr & hit_mstop)
                module_stop_control <= pwdata[15:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registered outputs
    wire in_reset = state_next == cxs_pkg::CXS_RESET;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpu_halt <= 1'b1;
            periph_init <= 1'b1;
            busport_init <= 1'b1;
            pins_to_ports <= 1'b1;
            push_req <= 1'b0;
            vec_fetch <= 1'b0;
            vec_addr <= 16'h0000;
            mem_addr <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            cpu_halt <= in_reset;
            periph_init <= in_reset;
            busport_init <= in_reset & ~reset_type_manual;
            pins_to_ports <= in_reset;
            push_req <= state_next == cxs_pkg::CXS_STACK;
            vec_fetch <= (state_reg == cxs_pkg::CXS_VEC) & ~in_reset;
            vec_addr <= vaddr;
            mem_addr <= cpu_addr & cxs_pkg::ADDR_EVEN_MASK;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_any;
            prdata <= 32'h0000_0000;
            if (psel & ~penable & ~pwrite)
            begin
                if (hit_ctrl)
                    prdata <= {29'h0, adv_reg, ctrl_mode};
                else if (hit_flags)
                    prdata <= {25'h0, lvl_reg, 1'b0, ui_reg, i_reg, t_reg};
                else if (hit_mstop)
                    prdata <= {16'h0000, module_stop_control};
                else if (hit_status)
                    prdata <= {24'h0, kind_trap_reg, kind_trace_reg, manual_reset_flag,
                               blocked_reg, trace_on, state_reg};
                else if (hit_vector)
                    prdata <= {9'h000, vec_num_reg, vaddr};
            end
        end
    end
endmodule : cxs_sequencer
`default_nettype wire

// *** include/cxs_pkg.sv ***
// Purpose: constants for the cpu exception sequencer
// Assumes: 125 MHz system clock
// Notes: vector numbers, mask layout, apb map
package cxs_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // vector numbers
    localparam logic [6:0] VEC_POWER_ON = 7'h00;
    localparam logic [6:0] VEC_MANUAL = 7'h01;
    localparam logic [6:0] VEC_TRACE = 7'h05;
    localparam logic [6:0] VEC_NMI = 7'h07;
    localparam logic [6:0] VEC_TRAP_BASE = 7'h08;
    localparam logic [6:0] VEC_EXT_BASE = 7'h10;
    localparam logic [6:0] VEC_INT_BASE = 7'h18;
    localparam logic [6:0] VEC_INT_LAST = 7'h57;
    localparam int unsigned NUM_EXT = 8;
    localparam int unsigned NUM_INT = 43;
    localparam logic [15:0] MSTOP_RESET = 16'h3fff;
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [15:0] ADDR_EVEN_MASK = 16'hfffe;
    // apb map (byte offsets)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_MSTOP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_VECTOR = 8'h10;
    // ctrl fields
    localparam int unsigned CTRL_MODE_LO = 0;
    localparam int unsigned CTRL_ADV = 2;
    // flags fields
    localparam int unsigned FL_T = 0;
    localparam int unsigned FL_I = 1;
    localparam int unsigned FL_UI = 2;
    localparam int unsigned FL_LVL_LO = 4;
    typedef enum logic [2:0]
    {
        CXS_RESET = 3'b011,
        CXS_RUN = 3'b100,
        CXS_STACK = 3'b101,
        CXS_VEC = 3'b111,
        CXS_JUMP = 3'b110
    } cxs_state_t;
endpackage : cxs_pkg

// *** sim/cxs_properties.sv ***
// Purpose: port-level checks of the exception sequencer
// Assumes: one clock, nrst async active low
// Notes: bound to cxs_sequencer after the module
`timescale 1ns/1ps
`default_nettype none
module cxs_seq_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched inputs
    input wire logic reset_pin_low,
    input wire logic [15:0] cpu_addr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic stack_done,
    // watched outputs
    input wire logic pready,
    input wire logic cpu_halt,
    input wire logic periph_init,
    input wire logic busport_init,
    input wire logic pins_to_ports,
    input wire logic push_req,
    input wire logic vec_fetch,
    input wire logic [15:0] vec_addr,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] module_stop_control,
    input wire logic [1:0] ctrl_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // advanced-mode bit as last written over the bus
    logic adv_seen;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            adv_seen <= 1'b0;
        else if (psel && penable && pwrite && pready && paddr == cxs_pkg::OFS_CTRL)
            adv_seen <= pwdata[cxs_pkg::CTRL_ADV];
    end
    chk_halt_on_pin: assert property ((!reset_pin_low) [*6] |-> cpu_halt && periph_init && pins_to_ports)
        else $error("cpu not halted under reset");
    chk_reset_first: assert property (cpu_halt |-> !push_req && !vec_fetch)
        else $error("exception activity during reset");
    chk_reset_mode: assert property (cpu_halt [*2] |-> ctrl_mode == cxs_pkg::MODE_0)
        else $error("control mode not 0 in reset");
    chk_stop_load: assert property ($fell(cpu_halt) |-> module_stop_control == cxs_pkg::MSTOP_RESET)
        else $error("module stop not loaded on release");
    chk_reset_jump: assert property ($fell(cpu_halt) |->
        !push_req throughout (##[0:4] (vec_fetch && vec_addr <= 16'h0004 && !vec_addr[0])))
        else $error("reset vector not fetched");
    chk_vec_table: assert property (vec_fetch |-> !vec_addr[0] && vec_addr < 16'h0160)
        else $error("vector address outside table");
    chk_no_trace0: assert property (vec_fetch && ctrl_mode == cxs_pkg::MODE_0 |->
        vec_addr != (adv_seen ? 16'h0014 : 16'h000a))
        else $error("trace taken in mode 0");
    chk_push_hold: assert property (push_req && !stack_done && reset_pin_low |=> push_req)
        else $error("stacking dropped early");
    chk_push_vec: assert property (push_req && stack_done && reset_pin_low |=> !push_req ##[0:2] vec_fetch)
        else $error("no vector after stacking");
    chk_word_even: assert property ($past(nrst) |-> mem_addr == ($past(cpu_addr) & cxs_pkg::ADDR_EVEN_MASK))
        else $error("memory address not word aligned");
    chk_busport_por: assert property (busport_init |-> periph_init && cpu_halt)
        else $error("bus and port init outside reset");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("apb access not answered");
endmodule : cxs_seq_properties
bind cxs_sequencer cxs_seq_properties u_props
(
    .clk, .nrst, .reset_pin_low, .cpu_addr, .psel, .penable, .pwrite, .paddr, .pwdata,
    .stack_done, .pready, .cpu_halt, .periph_init,
    .busport_init, .pins_to_ports, .push_req, .vec_fetch, .vec_addr, .mem_addr, .module_stop_control, .ctrl_mode
);
`default_nettype wire

// *** sim/cxs_cpu_model.sv ***
// Purpose: cpu pipeline side: answers stacking, reports stack setup
// Assumes: push_req is a level held until stack_done
// Notes: stacking takes 1 to 4 cycles at random
`timescale 1ns/1ps
`default_nettype none
module cxs_cpu_model
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // from sequencer
    input wire logic push_req,
    input wire logic vec_fetch,
    // to sequencer
    output logic stack_done,
    output logic sp_loaded
);
    int wait_cnt;
    logic [2:0] sp_dly;
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_cnt <= 0;
            stack_done <= 1'b0;
            sp_dly <= 3'h0;
            sp_loaded <= 1'b0;
        end
        else
        begin
            stack_done <= 1'b0;
            if (push_req && !stack_done && wait_cnt == 0)
                wait_cnt <= 1 + int'($urandom_range(3, 0));
            else if (wait_cnt == 1)
                stack_done <= 1'b1;
            if (wait_cnt > 0)
                wait_cnt <= wait_cnt - 1;
            // first handler instruction sets up the stack
            sp_dly <= {sp_dly[1:0], vec_fetch};
            sp_loaded <= sp_dly[2];
        end
    end
endmodule : cxs_cpu_model
`default_nettype wire

// *** sim/cxs_sequencer_tb.sv ***
// Purpose: self-checking bench for the exception sequencer
// Assumes: cpu model answers stacking
// Notes: fixed seed, random lines and addresses
`timescale 1ns/1ps
`default_nettype none
module cxs_sequencer_tb;
    logic clk = 1'b0, nrst = 1'b0, reset_pin_low = 1'b1, nmi_pin = 1'b1, wdt_overflow = 1'b0;
    logic wdt_type_manual = 1'b0, insn_done = 1'b0, insn_ctrl_op = 1'b0, trap_opcode = 1'b0, insn_rte = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, wt;
    logic [7:0] external_request_lines = 8'h00, paddr = 8'h00;
    logic [42:0] internal_requests = '0;
    logic [1:0] trap_num = 2'h0, rte_flags = 2'h0, ctrl_mode;
    logic [15:0] cpu_addr = 16'h0000, vec_addr, mem_addr, module_stop_control, va;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cpu_halt, periph_init, busport_init, pins_to_ports, push_req, vec_fetch;
    logic stack_done, sp_loaded, manual_reset_flag;
    int error_cnt = 0, num_checks = 0, cycles = 0, idx;
    int corner[4] = '{0, 7, 8, 50};
    cxs_sequencer DUT
    (
        .clk, .nrst, .reset_pin_low, .nmi_pin, .wdt_overflow, .wdt_type_manual, .external_request_lines,
        .internal_requests, .internal_level(3'h0), .insn_done, .insn_ctrl_op, .insn_rte, .rte_flags,
        .trap_opcode, .trap_num, .stack_done, .sp_loaded, .cpu_addr, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_halt, .periph_init, .busport_init, .pins_to_ports, .push_req,
        .vec_fetch, .vec_addr, .mem_addr, .module_stop_control, .ctrl_mode, .manual_reset_flag
    );
    cxs_cpu_model u_cpu (.clk, .nrst, .push_req, .vec_fetch, .stack_done, .sp_loaded);
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        cpu_addr <= 16'($urandom);
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] vaddr(input int num, input bit adv);
        return adv ? 16'(num * 4) : 16'(num * 2);
    endfunction : vaddr
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_vec();
        int n = 0;
        va = 16'hxxxx;
        while (vec_fetch !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (n < 300)
            va = vec_addr;
        @(posedge clk);
    endtask : wait_vec
    task automatic no_vec(input int cyc);
        int hits = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            hits += int'(vec_fetch === 1'b1);
        end
        check(32'(hits), 32'h0);
    endtask : no_vec
    task automatic pulse_done(input logic ctl);
        insn_ctrl_op <= ctl;
        insn_done <= 1'b1;
        @(posedge clk);
        insn_done <= 1'b0;
        insn_ctrl_op <= 1'b0;
    endtask : pulse_done
    task automatic pin_reset(input logic nmi_lvl, input logic [15:0] exp);
        nmi_pin <= nmi_lvl;
        reset_pin_low <= 1'b0;
        repeat (24) @(posedge clk);
        check(32'(cpu_halt & periph_init & pins_to_ports), 32'h1);
        check(32'(busport_init), 32'(nmi_lvl));
        check(32'(manual_reset_flag), 32'(!nmi_lvl));
        reset_pin_low <= 1'b1;
        @(posedge clk);
        wait_vec();
        check(32'(va), 32'(exp));
        apb(1'b0, cxs_pkg::OFS_MSTOP, 32'h0);
        check(32'(rd[15:0]), 32'(cxs_pkg::MSTOP_RESET));
        apb(1'b0, cxs_pkg::OFS_FLAGS, 32'h0);
        check(32'(rd[1:0]), 32'h2);
        $display("test reset done");
    endtask : pin_reset
    initial
    begin
        void'($urandom(32'hf311));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        pin_reset(1'b1, 16'h0000);
        apb(1'b1, cxs_pkg::OFS_CTRL, 32'h3);
        check(32'(ctrl_mode), 32'(cxs_pkg::MODE_0));
        for (int adv = 0; adv < 2; adv++)
            for (int n = 0; n < 4; n++)
            begin
                apb(1'b1, cxs_pkg::OFS_CTRL, 32'(adv) << cxs_pkg::CTRL_ADV);
                apb(1'b1, cxs_pkg::OFS_FLAGS, 32'h0);
                trap_num <= 2'(n);
                trap_opcode <= 1'b1;
                @(posedge clk);
                trap_opcode <= 1'b0;
                wait_vec();
                check(32'(va), 32'(vaddr(8 + n, adv[0])));
                apb(1'b0, cxs_pkg::OFS_FLAGS, 32'h0);
                check(32'(rd[cxs_pkg::FL_I]), 32'h1);
            end
        $display("test traps done");
        apb(1'b1, cxs_pkg::OFS_CTRL, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            idx = (k < 4) ? corner[k] : int'($urandom_range(50, 0));
            apb(1'b1, cxs_pkg::OFS_FLAGS, 32'h0);
            if (idx < 8)
                external_request_lines <= 8'(1 << idx);
            else
                internal_requests <= 43'(1) << (idx - 8);
            @(posedge clk);
            pulse_done(1'b1);
            no_vec(6);
            pulse_done(1'b0);
            wait_vec();
            external_request_lines <= 8'h00;
            internal_requests <= '0;
            check(32'(va), 32'(vaddr(16 + idx, 1'b0)));
        end
        $display("test interrupts done");
        apb(1'b1, cxs_pkg::OFS_CTRL, 32'(cxs_pkg::MODE_2));
        apb(1'b1, cxs_pkg::OFS_FLAGS, 32'h5);
        external_request_lines <= 8'h01;
        @(posedge clk);
        pulse_done(1'b0);
        wait_vec();
        external_request_lines <= 8'h00;
        check(32'(va), 32'(vaddr(5, 1'b0)));
        apb(1'b0, cxs_pkg::OFS_FLAGS, 32'h0);
        check(32'(rd[6:0]), 32'h6);
        apb(1'b1, cxs_pkg::OFS_FLAGS, 32'h1);
        insn_rte <= 1'b1;
        rte_flags <= 2'h1;
        pulse_done(1'b0);
        insn_rte <= 1'b0;
        no_vec(12);
        pulse_done(1'b0);
        wait_vec();
        check(32'(va), 32'(vaddr(5, 1'b0)));
        apb(1'b1, cxs_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, cxs_pkg::OFS_FLAGS, 32'h3);
        pulse_done(1'b0);
        no_vec(20);
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test trace done");
        nmi_pin <= 1'b0;
        repeat (6) @(posedge clk);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge clk);
        pulse_done(1'b0);
        wait_vec();
        check(32'(va), 32'(vaddr(7, 1'b0)));
        wt = 1'($urandom);
        wdt_type_manual <= wt;
        wdt_overflow <= 1'b1;
        repeat (4) @(posedge clk);
        wdt_overflow <= 1'b0;
        wait_vec();
        check(32'(va), 32'(vaddr(int'(wt), 1'b0)));
        pin_reset(1'b0, 16'h0002);
        stop_test();
    end
endmodule : cxs_sequencer_tb
`default_nettype wire
